/* File: ext_access_ctrl.sv */
`timescale 1ns/1ps
module ext_access_ctrl (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic start_i,
  output logic      emulator_chip_select_o,
  output logic      done_o
);

  reset_mode_pkg::ext_state_t state;
  reset_mode_pkg::ext_state_t next_state;
  logic [1:0]                 count;
  logic [1:0]                 next_count;

  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      reset_mode_pkg::EXT_IDLE: begin
        if (start_i) begin
          next_state = reset_mode_pkg::EXT_ACTIVE;
          next_count = 2'h0;
        end
      end
      reset_mode_pkg::EXT_ACTIVE: begin
        next_count = count + 2'h1;
        if (count == reset_mode_pkg::EXT_LAST_COUNT) begin
          next_state = reset_mode_pkg::EXT_DONE;
        end
      end
      default: begin
        next_state = reset_mode_pkg::EXT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= reset_mode_pkg::EXT_IDLE;
      count <= 2'h0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign emulator_chip_select_o = (state == reset_mode_pkg::EXT_ACTIVE);
  assign done_o                 = (state == reset_mode_pkg::EXT_DONE);

endmodule : ext_access_ctrl

/* File: pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage_a;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage_a <= '0;
      sync_o  <= '0;
    end else begin
      stage_a <= async_i;
      sync_o  <= stage_a;
    end
  end

endmodule : pin_sync

/* File: reset_mode_configuration.sv */
// How it works
// - bus-error input low during reset selects single-chip operation
// - single-chip: data pins become ports G/H, address 18..3 ports A/B
// - single-chip: no external data bus; ports A,B,C,E,F,G,H always selected
// - single-chip: low address pins float until disable bit cleared; resets set
// - single-chip: ports C, E, F take shared pins; keep cs0, grant, grant ack
// - clock-source pin high at reset selects synthesizer; low needs external clock
// - breakpoint pin low at reset release enables background debug
// - breakpoint pin high at reset release disables debug; normal exceptions
// - debug enable held until next reset; relatched at every release
// - data10 low, bus-error high, data1 low selects emulator mode
// - emulator: ports A,B,E,G,H registers mapped out; C data and F inside
// - external register access asserts emulator select at strobe fall; no reply
// - external register access lasts three clock cycles
// - data1,10,13 low with bus-error high enables ROM emulation select
// - ROM emulation: on-chip ROM never acknowledges, external cycle runs
// - flash variant drives ROM emulation select high when selected
// - out of reset, pins are ports with inputs selected
// - 8-bit expanded: boot cs, upper cs, grant pins fixed configuration
// - bus-error and data1 high during reset select 8-bit data bus
`timescale 1ns/1ps
module reset_mode_configuration #(
  parameter bit FLASH_VARIANT = 1'b0
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        bus_error_input_i,
  input  wire logic [15:0] data_pins_i,
  input  wire logic        clock_source_select_pin_i,
  input  wire logic        breakpoint_request_pin_i,
  input  wire logic        internal_breakpoint_i,
  input  wire logic        low_address_pin_disable_clear_i,
  input  wire logic        address_strobe_b_i,
  input  wire logic        ext_reg_select_i,
  input  wire logic [3:0]  reg_code_i,
  input  wire logic        rom_access_valid_i,
  output logic [1:0]       op_mode_o,
  output logic             single_chip_o,
  output logic             emulator_mode_o,
  output logic             rom_emulation_o,
  output logic             synth_enable_o,
  output logic             debug_enable_o,
  output logic             background_debug_state_o,
  output logic             breakpoint_exception_o,
  output logic             port_e_select_o,
  output logic             port_f_select_o,
  output logic             port_ab_select_o,
  output logic             port_g_select_o,
  output logic             port_h_select_o,
  output logic             port_c_select_o,
  output logic             external_data_bus_o,
  output logic             low_address_pin_disable_o,
  output logic             low_address_oe_o,
  output logic             fixed_chip_select_cfg_o,
  output logic [7:0]       port_dir_default_o,
  output logic             alt_function_enable_o,
  output logic             emulator_chip_select_o,
  output logic             ext_access_done_o,
  output logic             internal_respond_o,
  output logic             rom_emulation_chip_select_o,
  output logic             rom_acknowledge_o,
  output logic             external_bus_cycle_o
);

  // two-stage capture of pins from outside the clock domain
  logic [15:0] data_sync;
  logic [3:0]  misc_sync;
  logic        bus_error_sync;
  logic        clk_src_sync;
  logic        breakpoint_request_pin_sync;
  logic        strobe_sync;

  pin_sync #(.WIDTH(16)) u_sync_data (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (data_pins_i),
    .sync_o    (data_sync)
  );

  pin_sync #(.WIDTH(4)) u_sync_misc (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   ({bus_error_input_i, clock_source_select_pin_i,
                 breakpoint_request_pin_i, address_strobe_b_i}),
    .sync_o    (misc_sync)
  );

  assign bus_error_sync = misc_sync[3];
  assign clk_src_sync   = misc_sync[2];
  assign breakpoint_request_pin_sync      = misc_sync[1];
  assign strobe_sync    = misc_sync[0];

  // mode decode from the synchronised pins
  wire sel_single  = !bus_error_sync;
  wire sel_8bit    = bus_error_sync && data_sync[reset_mode_pkg::DATA_BIT_BUS8];
  wire sel_emul    = bus_error_sync && !data_sync[reset_mode_pkg::DATA_BIT_EMUL]
                     && !data_sync[reset_mode_pkg::DATA_BIT_BUS8];
  wire sel_rom_emu = sel_emul && !data_sync[reset_mode_pkg::DATA_BIT_ROM_EMUL];
  wire sel_pe      = !data_sync[reset_mode_pkg::DATA_BIT_PORTE];
  wire sel_pf      = !data_sync[reset_mode_pkg::DATA_BIT_PORTF];

  reset_mode_pkg::op_mode_t next_mode;
  assign next_mode = sel_single ? reset_mode_pkg::MODE_SINGLE_CHIP :
                     (sel_8bit  ? reset_mode_pkg::MODE_EXP_8 : reset_mode_pkg::MODE_EXP_16);

  // sampling runs for three cycles after release, one past the synchroniser delay, then freezes
  logic [1:0] settle;
  logic       latched;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      settle  <= 2'h0;
      latched <= 1'b0;
    end else if (!latched) begin
      settle  <= settle + 2'h1;
      latched <= (settle == 2'(reset_mode_pkg::SYNC_STAGES));
    end
  end

  reset_mode_pkg::op_mode_t mode;
  logic mode_emul;
  logic mode_rom_emu;
  logic mode_pe;
  logic mode_pf;
  logic mode_synth;
  logic mode_debug;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode         <= reset_mode_pkg::MODE_SINGLE_CHIP;
      mode_emul    <= 1'b0;
      mode_rom_emu <= 1'b0;
      mode_pe      <= 1'b1;
      mode_pf      <= 1'b1;
      mode_synth   <= 1'b1;
      mode_debug   <= 1'b0;
    end else if (!latched) begin
      mode         <= next_mode;
      mode_emul    <= sel_emul;
      mode_rom_emu <= sel_rom_emu;
      mode_pe      <= sel_pe;
      mode_pf      <= sel_pf;
      mode_synth   <= clk_src_sync;
      mode_debug   <= !breakpoint_request_pin_sync;
    end
  end

  wire is_single = (mode == reset_mode_pkg::MODE_SINGLE_CHIP);
  wire is_8bit   = (mode == reset_mode_pkg::MODE_EXP_8);

  assign op_mode_o       = mode;
  assign single_chip_o   = is_single;
  assign emulator_mode_o = mode_emul && !is_single;
  assign rom_emulation_o = mode_rom_emu && !is_single;
  assign synth_enable_o  = mode_synth;
  assign debug_enable_o  = mode_debug;

  // breakpoint routing after mode is settled
  wire breakpoint_request_pin_event = latched && (!breakpoint_request_pin_sync || internal_breakpoint_i);
  assign background_debug_state_o = breakpoint_request_pin_event && mode_debug;
  assign breakpoint_exception_o   = breakpoint_request_pin_event && !mode_debug;

  // pin-function selection
  assign port_ab_select_o    = is_single;
  assign port_g_select_o     = is_single;
  assign port_h_select_o     = is_single || is_8bit;
  assign port_c_select_o     = is_single;
  assign port_e_select_o     = is_single || mode_pe;
  assign port_f_select_o     = is_single || mode_pf;
  assign external_data_bus_o = !is_single;
  assign fixed_chip_select_cfg_o = is_8bit;

  // default port state out of reset
  assign port_dir_default_o    = reset_mode_pkg::PORT_DIR_RESET;
  assign alt_function_enable_o = 1'b0;

  // low address pin disable bit, set at reset
  logic low_addr_disable;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_addr_disable <= reset_mode_pkg::ADDR_LOW_DISABLE_RESET;
    end else if (low_address_pin_disable_clear_i) begin
      low_addr_disable <= 1'b0;
    end
  end

  assign low_address_pin_disable_o = low_addr_disable;
  assign low_address_oe_o = !(is_single && low_addr_disable);

  // externally mapped register decode
  wire code_ext = (reg_code_i == reset_mode_pkg::REG_PORT_A_DATA) ||
                  (reg_code_i == reset_mode_pkg::REG_PORT_A_DIR)  ||
                  (reg_code_i == reset_mode_pkg::REG_PORT_B_DATA) ||
                  (reg_code_i == reset_mode_pkg::REG_PORT_B_DIR)  ||
                  (reg_code_i == reset_mode_pkg::REG_PORT_E_DATA) ||
                  (reg_code_i == reset_mode_pkg::REG_PORT_E_DIR)  ||
                  (reg_code_i == reset_mode_pkg::REG_PORT_E_ASGN) ||
                  (reg_code_i == reset_mode_pkg::REG_PORT_G_DATA) ||
                  (reg_code_i == reset_mode_pkg::REG_PORT_G_DIR)  ||
                  (reg_code_i == reset_mode_pkg::REG_PORT_H_DATA) ||
                  (reg_code_i == reset_mode_pkg::REG_PORT_H_DIR);
  wire ext_hit  = emulator_mode_o && ext_reg_select_i && code_ext;

  // strobe falling edge from synchronised level
  logic strobe_prev;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strobe_prev <= 1'b0;
    end else begin
      strobe_prev <= strobe_sync;
    end
  end

  wire strobe_fall = strobe_prev && !strobe_sync;
  wire ext_start   = strobe_fall && ext_hit;

  ext_access_ctrl u_ext (
    .clk_sys_i              (clk_sys_i),
    .rst_b_i                (rst_b_i),
    .start_i                (ext_start),
    .emulator_chip_select_o (emulator_chip_select_o),
    .done_o                 (ext_access_done_o)
  );

  assign internal_respond_o = ext_reg_select_i && !ext_hit;

  // ROM emulation chip select and acknowledge
  assign rom_emulation_chip_select_o = rom_emulation_o &&
                                       (FLASH_VARIANT || rom_access_valid_i);
  assign rom_acknowledge_o    = rom_access_valid_i && !rom_emulation_o;
  assign external_bus_cycle_o = rom_access_valid_i && rom_emulation_o;

  chk_single_low_oe: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (is_single && low_addr_disable) |-> !low_address_oe_o)
    else $error("low address pins driven while disabled");
  chk_ext_three_cycles: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $rose(emulator_chip_select_o) |-> emulator_chip_select_o [*3] ##1 !emulator_chip_select_o)
    else $error("external access length wrong");
  chk_ext_no_reply: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    ext_hit |-> !internal_respond_o)
    else $error("device replied to external register");
  chk_ext_start: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    ext_start |=> emulator_chip_select_o)
    else $error("emulator select missing after strobe");
  chk_mode_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    latched |=> $stable(mode) && $stable(mode_debug))
    else $error("mode changed after latch");
  chk_rom_no_ack: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    rom_emulation_o |-> !rom_acknowledge_o)
    else $error("rom acknowledged during emulation");
  chk_single_ports: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    is_single |-> port_ab_select_o && port_g_select_o && port_e_select_o
                  && port_f_select_o && !external_data_bus_o)
    else $error("single-chip ports not selected");
  chk_debug_route: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    breakpoint_request_pin_event |-> (background_debug_state_o == mode_debug))
    else $error("breakpoint routing wrong");
  chk_latch_time: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !latched |-> ##[1:3] latched)
    else $error("mode latch late");
  chk_ext_from_strobe: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $rose(emulator_chip_select_o) |-> $past(ext_start))
    else $error("emulator select without strobe fall");
  chk_ext_done_after: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $fell(emulator_chip_select_o) |-> ext_access_done_o)
    else $error("access end not flagged");
  chk_ext_needs_emul: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    ext_start |-> emulator_mode_o)
    else $error("external access outside emulator mode");
  chk_single_no_emul: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    is_single |-> !emulator_mode_o && !rom_emulation_o)
    else $error("emulation active in single-chip mode");
  chk_ext_bus_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !is_single |-> external_data_bus_o && !port_ab_select_o && !port_g_select_o)
    else $error("expanded mode kept single-chip ports");
  chk_abd_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !low_addr_disable |=> !low_addr_disable)
    else $error("low address disable set again");
  chk_rom_cs_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !rom_emulation_o |-> !rom_emulation_chip_select_o)
    else $error("rom emulation select outside emulation");
  chk_rom_cs_window: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (!FLASH_VARIANT && !rom_access_valid_i) |-> !rom_emulation_chip_select_o)
    else $error("rom emulation select without access");
  chk_rom_ext_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (rom_emulation_o && rom_access_valid_i) |-> external_bus_cycle_o)
    else $error("no external cycle for emulated rom");
  chk_debug_split: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    breakpoint_request_pin_event |-> (background_debug_state_o != breakpoint_exception_o))
    else $error("breakpoint routed both ways");
  chk_no_event_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !breakpoint_request_pin_event |-> !background_debug_state_o && !breakpoint_exception_o)
    else $error("breakpoint routed without event");
  chk_synth_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    latched |=> $stable(mode_synth) && $stable(mode_emul) && $stable(mode_rom_emu))
    else $error("clock or emulation choice changed after latch");
  chk_8bit_fixed: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    is_8bit |-> fixed_chip_select_cfg_o && !emulator_mode_o)
    else $error("8-bit mode configuration wrong");

  cov_single: cover property (@(posedge clk_sys_i) latched && is_single);
  cov_emul: cover property (@(posedge clk_sys_i) $rose(emulator_chip_select_o));
  cov_rom: cover property (@(posedge clk_sys_i) rom_emulation_chip_select_o);
  cov_debug: cover property (@(posedge clk_sys_i) background_debug_state_o);
  cov_rom_ext: cover property (@(posedge clk_sys_i) external_bus_cycle_o);

endmodule : reset_mode_configuration

/* File: reset_mode_configuration_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end
module reset_mode_configuration_tb_top;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        internal_breakpoint_i = 1'b0;
  logic        low_address_pin_disable_clear_i = 1'b0;
  logic        address_strobe_b_i = 1'b1;
  logic        ext_reg_select_i = 1'b0;
  logic [3:0]  reg_code_i = 4'h0;
  logic        rom_access_valid_i = 1'b0;
  logic        strap_be = 1'b0, strap_clk = 1'b1, strap_breakpoint_request_pin = 1'b1, breakpoint_request_pin_req = 1'b0;
  logic [15:0] strap_data = 16'hFFFF;
  logic        bus_error_input_i, clock_source_select_pin_i, breakpoint_request_pin_i;
  logic [15:0] data_pins_i;
  logic [2:0]  reply_cycles;
  logic [1:0]  op_mode_o;
  logic        single_chip_o, emulator_mode_o, rom_emulation_o, synth_enable_o;
  logic        debug_enable_o, background_debug_state_o, breakpoint_exception_o;
  logic        port_e_select_o, port_f_select_o, port_ab_select_o, port_g_select_o;
  logic        port_h_select_o, port_c_select_o, external_data_bus_o;
  logic        low_address_pin_disable_o, low_address_oe_o, fixed_chip_select_cfg_o;
  logic [7:0]  port_dir_default_o;
  logic        alt_function_enable_o, emulator_chip_select_o, ext_access_done_o;
  logic        internal_respond_o, rom_emulation_chip_select_o, rom_acknowledge_o;
  logic        external_bus_cycle_o;
  logic [18:0] corner [5] = '{19'h3FFFF, 19'h4FFFF, 19'h7FBFD, 19'h6DBFD, 19'h5FCFF};
  int          error_cnt = 0;
  int          cmp_count = 0;
  logic        emu;

  reset_mode_configuration dut_u (
    .clk_sys_i, .rst_b_i, .bus_error_input_i, .data_pins_i, .clock_source_select_pin_i,
    .breakpoint_request_pin_i, .internal_breakpoint_i, .low_address_pin_disable_clear_i,
    .address_strobe_b_i, .ext_reg_select_i, .reg_code_i, .rom_access_valid_i, .op_mode_o,
    .single_chip_o, .emulator_mode_o, .rom_emulation_o, .synth_enable_o, .debug_enable_o,
    .background_debug_state_o, .breakpoint_exception_o, .port_e_select_o, .port_f_select_o,
    .port_ab_select_o, .port_g_select_o, .port_h_select_o, .port_c_select_o,
    .external_data_bus_o, .low_address_pin_disable_o, .low_address_oe_o,
    .fixed_chip_select_cfg_o, .port_dir_default_o, .alt_function_enable_o,
    .emulator_chip_select_o, .ext_access_done_o, .internal_respond_o,
    .rom_emulation_chip_select_o, .rom_acknowledge_o, .external_bus_cycle_o);

  strap_board_model board_u (
    .clk_sys_i, .rst_b_i, .strap_be_i(strap_be), .strap_data_i(strap_data),
    .strap_clk_i(strap_clk), .strap_breakpoint_request_pin_i(strap_breakpoint_request_pin), .breakpoint_request_pin_req_i(breakpoint_request_pin_req),
    .emulator_chip_select_i(emulator_chip_select_o), .bus_error_input_o(bus_error_input_i),
    .data_pins_o(data_pins_i), .clock_source_select_pin_o(clock_source_select_pin_i),
    .breakpoint_request_pin_o(breakpoint_request_pin_i), .reply_cycles_o(reply_cycles));

  always #5 clk_sys_i = ~clk_sys_i;

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic do_reset(input logic [18:0] cfg);
    @(posedge clk_sys_i);
    #1;
    {strap_be, strap_clk, strap_breakpoint_request_pin, strap_data} = cfg;
    rst_b_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1 rst_b_i = 1'b1;
    repeat (10) @(negedge clk_sys_i);
  endtask : do_reset

  task automatic check_cfg;
    logic [1:0] md;
    md = !strap_be ? reset_mode_pkg::MODE_SINGLE_CHIP :
         strap_data[1] ? reset_mode_pkg::MODE_EXP_8 : reset_mode_pkg::MODE_EXP_16;
    `CHK("op_mode", md, op_mode_o)
    `CHK("single", ~strap_be, single_chip_o)
    `CHK("emul", emu, emulator_mode_o)
    `CHK("rom_emul", emu & ~strap_data[13], rom_emulation_o)
    `CHK("synth", strap_clk, synth_enable_o)
    `CHK("debug_en", ~strap_breakpoint_request_pin, debug_enable_o)
    `CHK("dir_default", 8'h00, port_dir_default_o)
    `CHK("alt_func", 1'b0, alt_function_enable_o)
    if (!strap_be) begin
      `CHK("ports_abgh", 3'h7, {port_ab_select_o, port_g_select_o, port_h_select_o})
      `CHK("ports_cef", 3'h7, {port_c_select_o, port_e_select_o, port_f_select_o})
      `CHK("ext_bus", 1'b0, external_data_bus_o)
      `CHK("abd_reset", 2'b10, {low_address_pin_disable_o, low_address_oe_o})
      @(posedge clk_sys_i);
      #1 low_address_pin_disable_clear_i = 1'b1;
      @(posedge clk_sys_i);
      #1 low_address_pin_disable_clear_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      `CHK("abd_clear", 2'b01, {low_address_pin_disable_o, low_address_oe_o})
    end else begin
      `CHK("ports_abgc", 3'h0, {port_ab_select_o, port_g_select_o, port_c_select_o})
      `CHK("port_h", strap_data[1], port_h_select_o)
      `CHK("ports_ef", ~strap_data[9:8], {port_f_select_o, port_e_select_o})
      `CHK("ext_bus", 1'b1, external_data_bus_o)
      `CHK("abd_exp", 2'b11, {low_address_pin_disable_o, low_address_oe_o})
    end
    `CHK("fixed_cs", md == reset_mode_pkg::MODE_EXP_8, fixed_chip_select_cfg_o)
  endtask : check_cfg

  task automatic debug_event(input logic pin);
    @(posedge clk_sys_i);
    #1;
    internal_breakpoint_i = ~pin;
    breakpoint_request_pin_req = pin;
    repeat (3) @(negedge clk_sys_i);
    `CHK("bdm_entry", ~strap_breakpoint_request_pin, background_debug_state_o)
    `CHK("breakpoint_request_pin_exc", strap_breakpoint_request_pin, breakpoint_exception_o)
    @(posedge clk_sys_i);
    #1;
    internal_breakpoint_i = 1'b0;
    breakpoint_request_pin_req = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    `CHK("no_event", 2'b00, {background_debug_state_o, breakpoint_exception_o})
  endtask : debug_event

  task automatic ext_access(input logic [3:0] code, input int n_cs);
    int cs_n;
    int dn_n;
    cs_n = 0;
    dn_n = 0;
    @(posedge clk_sys_i);
    #1;
    reg_code_i = code;
    ext_reg_select_i = 1'b1;
    address_strobe_b_i = 1'b0;
    repeat (10) begin
      @(negedge clk_sys_i);
      cs_n += int'(emulator_chip_select_o === 1'b1);
      dn_n += int'(ext_access_done_o === 1'b1);
    end
    `CHK("internal_respond", n_cs == 0, internal_respond_o)
    `CHK("cse_cycles", n_cs, cs_n)
    `CHK("done_pulse", n_cs != 0, dn_n == 1)
    if (n_cs != 0) begin
      `CHK("reply_window", 3'h3, reply_cycles)
    end
    @(posedge clk_sys_i);
    #1;
    address_strobe_b_i = 1'b1;
    ext_reg_select_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask : ext_access

  initial begin
    logic [18:0] cfg;
    void'($urandom(32'hD4C0));
    for (int i = 0; i < 16; i++) begin
      cfg = (i < 5) ? corner[i] : 19'($urandom);
      do_reset(cfg);
      emu = strap_be & ~strap_data[10] & ~strap_data[1];
      check_cfg();
      debug_event(1'b0);
      debug_event(1'b1);
      for (int c = 0; c < 12; c++) begin
        ext_access(4'(c), (emu && c < 11) ? 3 : 0);
      end
      @(posedge clk_sys_i);
      #1 rom_access_valid_i = 1'b1;
      @(negedge clk_sys_i);
      `CHK("rom_cs", emu & ~strap_data[13], rom_emulation_chip_select_o)
      if (emu & ~strap_data[13]) begin
        `CHK("rom_ack", 2'b01, {rom_acknowledge_o, external_bus_cycle_o})
      end else begin
        `CHK("rom_ack", 2'b10, {rom_acknowledge_o, external_bus_cycle_o})
      end
      @(posedge clk_sys_i);
      #1 rom_access_valid_i = 1'b0;
    end
    close_out();
  end

  initial begin
    #500000;
    error_cnt++;
    close_out();
  end
endmodule : reset_mode_configuration_tb_top

/* File: reset_mode_pkg.sv */
package reset_mode_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP = 2'b00,
    MODE_EXP_8       = 2'b01,
    MODE_EXP_16      = 2'b10
  } op_mode_t;

  typedef enum logic [1:0] {
    EXT_IDLE   = 2'b00,
    EXT_ACTIVE = 2'b01,
    EXT_DONE   = 2'b10
  } ext_state_t;

  // data-pin positions sampled as mode selects
  localparam int DATA_BIT_BUS8     = 1;
  localparam int DATA_BIT_PORTE    = 8;
  localparam int DATA_BIT_PORTF    = 9;
  localparam int DATA_BIT_EMUL     = 10;
  localparam int DATA_BIT_NORMAL   = 11;
  localparam int DATA_BIT_ROM_EMUL = 13;

  localparam int SYNC_STAGES = 2;

  // externally mapped access length
  localparam int EXT_ACCESS_CYCLES = 3;
  localparam logic [1:0] EXT_LAST_COUNT = 2'(EXT_ACCESS_CYCLES - 1);

  localparam logic ADDR_LOW_DISABLE_RESET = 1'b1;
  localparam logic [7:0] PORT_DIR_RESET   = 8'h00;

  // external-map register select codes
  localparam logic [3:0] REG_PORT_A_DATA = 4'h0;
  localparam logic [3:0] REG_PORT_A_DIR  = 4'h1;
  localparam logic [3:0] REG_PORT_B_DATA = 4'h2;
  localparam logic [3:0] REG_PORT_B_DIR  = 4'h3;
  localparam logic [3:0] REG_PORT_E_DATA = 4'h4;
  localparam logic [3:0] REG_PORT_E_DIR  = 4'h5;
  localparam logic [3:0] REG_PORT_E_ASGN = 4'h6;
  localparam logic [3:0] REG_PORT_G_DATA = 4'h7;
  localparam logic [3:0] REG_PORT_G_DIR  = 4'h8;
  localparam logic [3:0] REG_PORT_H_DATA = 4'h9;
  localparam logic [3:0] REG_PORT_H_DIR  = 4'hA;

endpackage : reset_mode_pkg

/* File: strap_board_model.sv */
`timescale 1ns/1ps
module strap_board_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        strap_be_i,
  input  wire logic [15:0] strap_data_i,
  input  wire logic        strap_clk_i,
  input  wire logic        strap_breakpoint_request_pin_i,
  input  wire logic        breakpoint_request_pin_req_i,
  input  wire logic        emulator_chip_select_i,
  output logic             bus_error_input_o,
  output logic [15:0]      data_pins_o,
  output logic             clock_source_select_pin_o,
  output logic             breakpoint_request_pin_o,
  output logic [2:0]       reply_cycles_o
);
  logic [2:0] hold_cnt;
  logic       flip;
  logic       holding;
  logic       cse_q;
  // straps held through reset and four edges after, then the bus is released
  assign holding = !rst_b_i || hold_cnt != 3'h4;
  assign data_pins_o = holding ? (strap_data_i | 16'h0800) : (~strap_data_i ^ {16{flip}});
  assign bus_error_input_o = holding ? strap_be_i : flip;
  assign clock_source_select_pin_o = holding ? strap_clk_i : ~flip;
  assign breakpoint_request_pin_o = holding ? strap_breakpoint_request_pin_i : ~breakpoint_request_pin_req_i;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_cnt <= 3'h0;
      flip     <= 1'b0;
    end else begin
      hold_cnt <= holding ? hold_cnt + 3'h1 : hold_cnt;
      flip     <= holding ? 1'b0 : ~flip;
    end
  end
  // port replacement side: length of the select window it answers in
  always_ff @(posedge clk_sys_i) begin
    cse_q <= emulator_chip_select_i;
    if (emulator_chip_select_i) begin
      reply_cycles_o <= cse_q ? reply_cycles_o + 3'h1 : 3'h1;
    end
  end
endmodule : strap_board_model
